// File: rtl/odp_defs.vh
// constants for the open-drain pin configuration block
`ifndef ODP_DEFS_VH
`define ODP_DEFS_VH
// apb byte addresses
`define ODP_ADDR_FUNC_SEL   8'h00
`define ODP_ADDR_PIN_STATE  8'h04
`define ODP_ADDR_LINE_STAT  8'h08
`define ODP_ADDR_LINE_CTRL  8'h0c
// selector field positions
`define ODP_PIN3_MSB 7
`define ODP_PIN3_LSB 6
`define ODP_PIN2_MSB 5
`define ODP_PIN2_LSB 4
`define ODP_PIN1_MSB 3
`define ODP_PIN1_LSB 2
`define ODP_PIN0_MSB 1
`define ODP_PIN0_LSB 0
// selector codes
`define ODP_SEL_INPUT 2'h0
`define ODP_SEL_ALERT 2'h1
`define ODP_SEL_LOW   2'h2
`define ODP_SEL_HIZ   2'h3
// reset values
`define ODP_FUNC_SEL_RST  8'h00
`define ODP_PIN_STATE_RST 8'hf0
// line timing, 10 MHz clock
`define ODP_CLK_HZ        10000000
`define ODP_RESET_LOW_US  480
`define ODP_ONE_MAX_US    15
`define ODP_RESET_CYC     ((`ODP_RESET_LOW_US * (`ODP_CLK_HZ / 1000000)))
`define ODP_ONE_MAX_CYC   ((`ODP_ONE_MAX_US * (`ODP_CLK_HZ / 1000000)))
`define ODP_ZERO_HOLD_US  60
`define ODP_ZERO_HOLD_CYC ((`ODP_ZERO_HOLD_US * (`ODP_CLK_HZ / 1000000)))
`define ODP_CNT_W         16
`endif

// File: rtl/odp_pulse_timer.v
// low-pulse width classifier for the shared data line
`timescale 1ns/10ps
`default_nettype none
`include "odp_defs.vh"

module odp_pulse_timer
(
   input  wire       clk,
   input  wire       rst,
   input  wire       line_in,
   output reg        is_reset_q,
   output reg        is_one_q,
   output reg        is_zero_q,
   output wire       fall_pulse
);
   reg                  prev_q;
   reg [`ODP_CNT_W-1:0] cnt_q;
   wire                 rise;

   assign fall_pulse = prev_q & ~line_in;
   assign rise       = ~prev_q & line_in;

   // =============================================
   // low period counter and classification
   always @(posedge clk)
   begin
      if (rst)
      begin
         prev_q     <= 1'b1;
         cnt_q      <= {`ODP_CNT_W{1'b0}};
         is_reset_q <= 1'b0;
         is_one_q   <= 1'b0;
         is_zero_q  <= 1'b0;
      end
      else
      begin
         prev_q     <= line_in;
         is_reset_q <= 1'b0;
         is_one_q   <= 1'b0;
         is_zero_q  <= 1'b0;
         if (!line_in)
         begin
            // saturate so a very long low still reads as reset
            if (cnt_q != {`ODP_CNT_W{1'b1}})
               cnt_q <= cnt_q + 1'b1;
         end
         else
            cnt_q <= {`ODP_CNT_W{1'b0}};
         if (rise)
         begin
            if (cnt_q >= `ODP_RESET_CYC)
               is_reset_q <= 1'b1;
            else if (cnt_q <= `ODP_ONE_MAX_CYC)
               is_one_q <= 1'b1;
            else
               is_zero_q <= 1'b1;
         end
      end
   end
endmodule // odp_pulse_timer
`default_nettype wire

// File: rtl/odp_pin_config.v
// open-drain general pin configuration with apb access and line decode
`timescale 1ns/10ps
`default_nettype none
`include "odp_defs.vh"

module odp_pin_config
(
   input  wire        clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire [3:0]  general_pin_in,
   output wire [3:0]  general_pin_out,
   output wire [3:0]  general_pin_oe,
   input  wire        temp_alert,
   input  wire        shared_data_line_in,
   output wire        shared_data_line_out,
   output wire        shared_data_line_oe
);
   // =============================================
   // storage
   reg  [7:0] func_sel_q;
   reg  [7:0] pin_state_q;
   reg  [3:0] pin_s1_q;
   reg  [3:0] pin_s2_q;
   reg        line_s1_q;
   reg        line_s2_q;
   reg        tx_arm_q;
   reg        tx_bit_q;
   reg        hold_q;
   reg [`ODP_CNT_W-1:0] hold_cnt_q;
   reg  [2:0] evt_q;
   wire       is_reset;
   wire       is_one;
   wire       is_zero;
   wire       fall;
   wire [3:0] drive_low;
   wire [3:0] sel_vec;
   wire       wr_en;
   wire       rd_hit;
   wire       pin_read_cmd;
   integer    i;

   // full-width hold count, cut on purpose to the counter width
   localparam [31:0] HOLD_FULL = `ODP_ZERO_HOLD_CYC;

   // selector for pin n, reserved code folded onto input
   function [1:0] sel_of;
      input [7:0] cfg;
      input [1:0] n;
      reg   [1:0] s;
      begin
         s = cfg[{n, 1'b0} +: 2];
         if (s == `ODP_SEL_ALERT && n != 2'd2)
            sel_of = `ODP_SEL_INPUT;
         else
            sel_of = s;
      end
   endfunction

   // =============================================
   // apb slave, zero wait states
   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign rd_hit  = (paddr == `ODP_ADDR_PIN_STATE) | (paddr == `ODP_ADDR_LINE_STAT)
                  | (paddr == `ODP_ADDR_FUNC_SEL) | (paddr == `ODP_ADDR_LINE_CTRL);
   // unmapped addresses report an error
   assign pslverr = psel & penable & ~rd_hit;
   // software pin-state read command also refreshes the snapshot
   assign pin_read_cmd = wr_en & (paddr == `ODP_ADDR_LINE_CTRL) & pwdata[0];

   always @*
   begin
      prdata = 32'h0;
      if (psel && !pwrite)
      begin
         case (paddr)
            `ODP_ADDR_PIN_STATE: prdata = {24'h0, pin_state_q};
            `ODP_ADDR_LINE_STAT: prdata = {29'h0, evt_q};
            // selector register is write only and reads zero
            default:             prdata = 32'h0;
         endcase
      end
   end

   // =============================================
   // configuration register and pin-state snapshot
   always @(posedge clk)
   begin
      if (rst)
      begin
         func_sel_q  <= `ODP_FUNC_SEL_RST;
         pin_state_q <= `ODP_PIN_STATE_RST;
         tx_bit_q    <= 1'b1;
         tx_arm_q    <= 1'b0;
      end
      else
      begin
         if (wr_en && paddr == `ODP_ADDR_FUNC_SEL)
            func_sel_q <= pwdata[7:0];
         if (wr_en && paddr == `ODP_ADDR_LINE_CTRL)
         begin
            tx_arm_q <= pwdata[1];
            tx_bit_q <= pwdata[2];
         end
         else if (fall && tx_arm_q)
            tx_arm_q <= 1'b0;
         if (pin_read_cmd)
         begin
            pin_state_q[3:0] <= pin_s2_q;
            pin_state_q[7:4] <= ~pin_s2_q;
            if (sel_vec[2])
            begin
               // alert status in place of the pin level
               pin_state_q[2] <= temp_alert;
               pin_state_q[6] <= ~temp_alert;
            end
         end
      end
   end

   // =============================================
   // pin drivers: open drain only, never drive high
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_pin
         localparam [31:0] GI = g;
         wire [1:0] s = sel_of(func_sel_q, GI[1:0]);
         assign drive_low[g] = (s == `ODP_SEL_LOW)
                             | (g == 2 && s == `ODP_SEL_ALERT && temp_alert);
         assign sel_vec[g] = (g == 2) && (s == `ODP_SEL_ALERT);
      end
   endgenerate
   assign general_pin_out = 4'h0;
   assign general_pin_oe  = drive_low;

   // =============================================
   // synchronisers for pins and line
   always @(posedge clk)
   begin
      if (rst)
      begin
         pin_s1_q  <= 4'h0;
         pin_s2_q  <= 4'h0;
         line_s1_q <= 1'b1;
         line_s2_q <= 1'b1;
      end
      else
      begin
         pin_s1_q  <= general_pin_in;
         pin_s2_q  <= pin_s1_q;
         line_s1_q <= shared_data_line_in;
         line_s2_q <= line_s1_q;
      end
   end

   odp_pulse_timer u_timer
   (
      .clk        (clk),
      .rst        (rst),
      .line_in    (line_s2_q),
      .is_reset_q (is_reset),
      .is_one_q   (is_one),
      .is_zero_q  (is_zero),
      .fall_pulse (fall)
   );

   // =============================================
   // line events and bit answer
   always @(posedge clk)
   begin
      if (rst)
      begin
         evt_q      <= 3'h0;
         hold_q     <= 1'b0;
         hold_cnt_q <= {`ODP_CNT_W{1'b0}};
      end
      else
      begin
         // sticky; a new event wins over the clear
         for (i = 0; i < 3; i = i + 1)
            if (wr_en && paddr == `ODP_ADDR_LINE_STAT && pwdata[i])
               evt_q[i] <= 1'b0;
         if (is_reset) evt_q[0] <= 1'b1;
         if (is_one)   evt_q[1] <= 1'b1;
         if (is_zero)  evt_q[2] <= 1'b1;
         if (fall && tx_arm_q && !tx_bit_q)
         begin
            hold_q     <= 1'b1;
            hold_cnt_q <= HOLD_FULL[`ODP_CNT_W-1:0];
         end
         else if (hold_q)
         begin
            if (hold_cnt_q == {{(`ODP_CNT_W-1){1'b0}}, 1'b1})
               hold_q <= 1'b0;
            hold_cnt_q <= hold_cnt_q - 1'b1;
         end
      end
   end

   // a one is sent by simply never pulling low
   assign shared_data_line_out = 1'b0;
   assign shared_data_line_oe  = hold_q;
endmodule // odp_pin_config
`default_nettype wire

// File: dv/odp_pin_config_chk.sv
// assertion checker for the pin configuration block
`timescale 1ns/10ps
`default_nettype none
module odp_pin_config_chk
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic [3:0]  general_pin_out,
   input wire logic [3:0]  general_pin_oe,
   input wire logic        temp_alert,
   input wire logic        shared_data_line_out,
   input wire logic        shared_data_line_oe
);
   logic [7:0] cfg_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ====
   // shadow copy, since the selectors cannot be read back
   always_ff @(posedge clk)
      if (rst)
         cfg_q <= 8'h00;
      else if (psel && penable && pwrite && paddr == 8'h00)
         cfg_q <= pwdata[7:0];
   sequence s_hold;
      shared_data_line_oe [*8];
   endsequence
   AST_FIELD: assert property (cfg_q[7:6] == 2'h2 |-> general_pin_oe[3])
      else $error("pin3 field not low");
   AST_RST: assert property ($past(rst) |-> general_pin_oe == 4'h0)
      else $error("pins driven after reset");
   AST_WO: assert property (psel && !pwrite && paddr == 8'h00 |-> prdata == 32'h0)
      else $error("selector readable");
   AST_IN: assert property (cfg_q[3:2] == 2'h0 |-> !general_pin_oe[1])
      else $error("input pin driven");
   AST_LOW: assert property (cfg_q[1:0] == 2'h2 |-> general_pin_oe[0])
      else $error("pin0 not low");
   AST_HIZ: assert property (cfg_q[5:4] == 2'h3 |-> !general_pin_oe[2])
      else $error("released pin driven");
   AST_NOHI: assert property (general_pin_out == 4'h0 && !shared_data_line_out)
      else $error("pin driven high");
   AST_ALERT: assert property (cfg_q[5:4] == 2'h1 |-> general_pin_oe[2] == temp_alert)
      else $error("alert level wrong");
   AST_RSV: assert property (cfg_q[1:0] == 2'h1 |-> !general_pin_oe[0])
      else $error("reserved code drives");
   AST_ANS: assert property ($rose(shared_data_line_oe) |-> s_hold)
      else $error("answer low too short");
endmodule // odp_pin_config_chk
bind odp_pin_config odp_pin_config_chk i_chk (.*);
`default_nettype wire

// File: dv/odp_host_model.sv
// host on the shared data line, open drain with pull-up
`timescale 1ns/10ps
`default_nettype none
module odp_host_model
(
   input wire logic clk,
   input wire logic dev_oe,
   output var logic line
);
   logic host_low = 1'b0;
   // model charge-up time after power is applied; value is arbitrary
   localparam int CHARGE_CYC = 50;
   // forced power-on reset: 50 ms of low at 100 ns per cycle
   localparam int POR_LOW_CYC = 500000;
   int up_cyc = 0;
   always @(posedge clk)
      if (up_cyc < CHARGE_CYC)
         up_cyc <= up_cyc + 1;
   // ====
   // never drives high: released line floats up
   assign line = !(host_low || dev_oe);
   task automatic low_pulse(input int n);
      for (int k = 0; k < CHARGE_CYC && up_cyc < CHARGE_CYC; k++)
         @(posedge clk);
      host_low <= 1'b1;
      repeat (n) @(posedge clk);
      host_low <= 1'b0;
      @(posedge clk);
   endtask
   // drains the device supply; too long for the short run, so not called there
   task automatic por_hold;
      low_pulse(POR_LOW_CYC);
   endtask
endmodule // odp_host_model
`default_nettype wire

// File: dv/odp_pin_config_tb.sv
// self-checking bench for the pin configuration block
`timescale 1ns/10ps
`default_nettype none
module odp_pin_config_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   // general pins are kept off the shared line, so outputs are safe
   logic [3:0]  pin_in = 4'h0;
   logic        alert = 1'b0;
   logic [31:0] rd;
   logic        er;
   wire         pready, pslverr, line, line_oe;
   wire  [31:0] prdata;
   wire  [3:0]  oe;
   int          failures = 0;
   int          n_tests = 0;
   always #50 clk = ~clk;
   odp_pin_config i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .general_pin_in(pin_in), .general_pin_out(), .general_pin_oe(oe),
      .temp_alert(alert), .shared_data_line_in(line), .shared_data_line_out(),
      .shared_data_line_oe(line_oe));
   odp_host_model i_host (.clk(clk), .dev_oe(line_oe), .line(line));
   // ====
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         failures++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next call never reassigns psel in this step
      @(posedge clk);
   endtask
   // ====
   initial
   begin
      int w[3] = '{100, 200, 4900};
      int e[3] = '{2, 4, 1};
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(0, 8'h00, 0);
      chk("sel", 0, rd);
      chk("oe", 0, {28'h0, oe});
      apb(0, 8'h04, 0);
      chk("state", 32'hf0, rd);
      $display("reset test done");
      for (int c = 0; c < 4; c++)
      begin
         alert <= c[0];
         apb(1, 8'h00, {24'h0, {4{c[1:0]}}});
         @(posedge clk);
         chk("oe", c == 2 ? 15 : c == 1 ? 4 : 0, {28'h0, oe});
      end
      alert <= 1'b0;
      apb(1, 8'h00, 32'h9e);
      @(posedge clk);
      chk("oe", 9, {28'h0, oe});
      apb(0, 8'h00, 0);
      chk("sel", 0, rd);
      $display("code test done");
      apb(1, 8'h00, 0);
      pin_in <= 4'ha;
      repeat (4) @(posedge clk);
      apb(0, 8'h04, 0);
      chk("state", 32'hf0, rd);
      apb(1, 8'h0c, 1);
      repeat (4) @(posedge clk);
      apb(0, 8'h04, 0);
      chk("state", 32'h5a, rd);
      apb(1, 8'h00, 32'h10);
      alert <= 1'b1;
      apb(1, 8'h0c, 1);
      apb(0, 8'h04, 0);
      chk("state", 32'h1e, rd);
      alert <= 1'b0;
      $display("pin state test done");
      for (int i = 0; i < 3; i++)
      begin
         apb(1, 8'h08, 7);
         i_host.low_pulse(w[i]);
         repeat (6) @(posedge clk);
         apb(0, 8'h08, 0);
         chk("event", e[i], rd);
      end
      $display("decode test done");
      for (int b = 0; b < 2; b++)
      begin
         apb(1, 8'h0c, b ? 6 : 2);
         i_host.low_pulse(10);
         repeat (20) @(posedge clk);
         chk("answer", b, {31'h0, line});
         repeat (700) @(posedge clk);
         chk("release", 1, {31'h0, line});
      end
      $display("answer test done");
      apb(0, 8'h10, 0);
      chk("err", 1, {31'h0, er});
      chk("data", 0, rd);
      $display("unmapped test done");
      end_of_test();
   end
endmodule // odp_pin_config_tb
`default_nettype wire
